/* File: core/power_switchover_pkg.sv */
package power_switchover_pkg;
  // ---------------------------------------------------------------
  // register addresses on the special function register port
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'hc1;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'hc5;
  localparam logic [7:0] ADDR_INT_ENABLE_PRIORITY2 = 8'ha9;
  localparam logic [7:0] ADDR_POWER_EVENT_ENABLE = 8'hec;
  localparam logic [7:0] ADDR_SWITCHOVER_CONFIG = 8'hf5;
  localparam logic [7:0] ADDR_PERIPHERAL_CONFIG = 8'hf4;
  localparam logic [7:0] ADDR_POWER_EVENT_FLAGS = 8'hf8;
  localparam logic [7:0] UNLOCK_VALUE = 8'ha7;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PC_METER_OFF = 6;
  localparam int PC_RSVD5 = 5;
  localparam int PC_CORE_SHUTDOWN = 4;
  localparam int SC_DISABLE = 1;
  localparam int PERIPHERAL_SOURCE = 6;
  localparam int EV_SWITCHOVER = 1;
  localparam int EV_RESTORED = 7;
  localparam int IE2_MASTER = 1;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] POWER_CONTROL_RST = 8'h82;
  localparam logic [7:0] POWER_CONTROL_MASK = 8'hd7;
  localparam logic [7:0] EVENT_IMPL_MASK = 8'h82;
  localparam logic [1:0] SWITCHOVER_CONFIG_RST = 2'h0;
  localparam logic [2:0] EXT_INT1_PIN_EN = 3'h1;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int RESTORE_MS = 130;
  localparam int RESTORE_CYCLES = RESTORE_MS * 1000 * CLK_MHZ;
  localparam int RESTORE_W = 26;
  typedef enum logic [1:0] {
    ON_MAIN = 2'b01,
    ON_BATTERY = 2'b10
  } source_t;
endpackage : power_switchover_pkg

/* File: core/power_switchover_control.sv */
`timescale 1ns/1ps
module power_switchover_control
  import power_switchover_pkg::*;
#(
  parameter int RESTORE_DELAY = RESTORE_CYCLES
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [2:0] ext_int1_config,
  input wire logic main_supply_ok,
  input wire logic supervisory_input_ok,
  input wire logic battery_control_pin,
  output logic internal_rail_on_battery,
  output logic metering_powerdown,
  output logic metering_converters_avail,
  output logic core_halt,
  output logic sleep_mode,
  output logic [2:0] clock_divide,
  output logic [12:0] core_clock_khz,
  output logic power_int_req
);
  import power_switchover_pkg::*;

  // -------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------
  logic [2:0] meta_r, meta_nxt;
  logic [2:0] sync_r, sync_nxt;
  logic pin_prev_r, pin_prev_nxt;
  // order: main ok, supervisory ok, battery pin
  always_comb
  begin
    meta_nxt = {main_supply_ok, supervisory_input_ok, battery_control_pin};
    sync_nxt = meta_r;
    pin_prev_nxt = sync_r[0];
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_r <= 3'h7;
      sync_r <= 3'h7;
      pin_prev_r <= 1'b1;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      pin_prev_r <= pin_prev_nxt;
    end
  end
  logic main_ok, dcin_ok, pin_hi;
  assign main_ok = sync_r[2];
  assign dcin_ok = sync_r[1];
  assign pin_hi = sync_r[0];

  // -------------------------------------------------------------
  // register file
  // -------------------------------------------------------------
  logic [7:0] power_control_r, power_control_nxt;
  logic unlocked_r, unlocked_nxt;
  logic [1:0] switchover_config_r, switchover_config_nxt;
  logic [7:0] power_event_enable_r, power_event_enable_nxt;
  logic [7:0] power_event_flags_r, power_event_flags_nxt;
  logic master_en_r, master_en_nxt;
  logic ev_switchover, ev_restored;
  always_comb
  begin
    power_control_nxt = power_control_r;
    unlocked_nxt = unlocked_r;
    switchover_config_nxt = switchover_config_r;
    power_event_enable_nxt = power_event_enable_r;
    power_event_flags_nxt = power_event_flags_r;
    master_en_nxt = master_en_r;
    if (sfr_wr)
    begin
      // any other write closes the key
      unlocked_nxt = 1'b0;
      if (sfr_addr == ADDR_UNLOCK_KEY)
      begin
        unlocked_nxt = (sfr_wdata == UNLOCK_VALUE);
      end
      else if (sfr_addr == ADDR_POWER_CONTROL)
      begin
        if (unlocked_r)
        begin
          // bit 7 held one, bits 5 and 3 held zero
          power_control_nxt = (sfr_wdata & POWER_CONTROL_MASK) | 8'h80;
        end
      end
      else if (sfr_addr == ADDR_SWITCHOVER_CONFIG)
      begin
        switchover_config_nxt = sfr_wdata[1:0];
      end
      else if (sfr_addr == ADDR_POWER_EVENT_ENABLE)
      begin
        power_event_enable_nxt = sfr_wdata & EVENT_IMPL_MASK;
      end
      else if (sfr_addr == ADDR_POWER_EVENT_FLAGS)
      begin
        power_event_flags_nxt = power_event_flags_r & sfr_wdata;
      end
      else if (sfr_addr == ADDR_INT_ENABLE_PRIORITY2)
      begin
        master_en_nxt = sfr_wdata[IE2_MASTER];
      end
    end
    // events set regardless of enables; set beats clear
    if (ev_switchover)
    begin
      power_event_flags_nxt[EV_SWITCHOVER] = 1'b1;
    end
    if (ev_restored)
    begin
      power_event_flags_nxt[EV_RESTORED] = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      power_control_r <= POWER_CONTROL_RST;
      unlocked_r <= 1'b0;
      switchover_config_r <= SWITCHOVER_CONFIG_RST;
      power_event_enable_r <= 8'h00;
      power_event_flags_r <= 8'h00;
      master_en_r <= 1'b0;
    end
    else
    begin
      power_control_r <= power_control_nxt;
      unlocked_r <= unlocked_nxt;
      switchover_config_r <= switchover_config_nxt;
      power_event_enable_r <= power_event_enable_nxt;
      power_event_flags_r <= power_event_flags_nxt;
      master_en_r <= master_en_nxt;
    end
  end

  // -------------------------------------------------------------
  // supply source selection
  // -------------------------------------------------------------
  source_t state_r, state_nxt;
  logic [RESTORE_W-1:0] restore_cnt_r, restore_cnt_nxt;
  logic auto_en, dcin_en, pin_en, to_battery, restore_ok;
  always_comb
  begin
    auto_en = ~switchover_config_r[SC_DISABLE];
    dcin_en = auto_en & switchover_config_r[0];
    // pin enabled by ext int1 x01
    pin_en = (ext_int1_config[1:0] == EXT_INT1_PIN_EN[1:0]);
    // low main supply always counts when enabled
    to_battery = (auto_en & ~main_ok) | (dcin_en & ~dcin_ok);
    // falling pin edge, only while auto switchover and the pin are enabled
    if (auto_en & pin_en & pin_prev_r & ~pin_hi)
    begin
      to_battery = 1'b1;
    end
    restore_ok = main_ok & (~dcin_en | dcin_ok) & (~pin_en | pin_hi);
    state_nxt = state_r;
    restore_cnt_nxt = '0;
    ev_switchover = 1'b0;
    ev_restored = 1'b0;
    case (state_r)
      ON_MAIN:
      begin
        if (to_battery)
        begin
          state_nxt = ON_BATTERY;
          ev_switchover = 1'b1;
        end
      end
      ON_BATTERY:
      begin
        if (!auto_en)
        begin
          state_nxt = ON_MAIN;
          ev_restored = 1'b1;
        end
        // conditions must remain true for the restore delay
        else if (restore_ok)
        begin
          if (restore_cnt_r == RESTORE_W'(RESTORE_DELAY - 1))
          begin
            state_nxt = ON_MAIN;
            ev_restored = 1'b1;
          end
          else
          begin
            restore_cnt_nxt = restore_cnt_r + 1'b1;
          end
        end
      end
      default:
      begin
        state_nxt = ON_MAIN;
      end
    endcase
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= ON_MAIN;
      restore_cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      restore_cnt_r <= restore_cnt_nxt;
    end
  end

  // -------------------------------------------------------------
  // outputs and read mux
  // -------------------------------------------------------------
  logic on_batt;
  assign on_batt = (state_r == ON_BATTERY);
  assign internal_rail_on_battery = on_batt;
  // metering off only meaningful in normal mode
  assign metering_powerdown = power_control_r[PC_METER_OFF] | on_batt;
  assign metering_converters_avail = ~on_batt & ~power_control_r[PC_METER_OFF];
  // core shutdown only acts in battery mode
  assign sleep_mode = power_control_r[PC_CORE_SHUTDOWN] & on_batt;
  assign core_halt = sleep_mode;
  assign clock_divide = power_control_r[2:0];
  // 4096 khz shifted down by the divide code
  assign core_clock_khz = 13'h1000 >> power_control_r[2:0];
  // enabled flags share one request behind master enable
  assign power_int_req =
    master_en_r & |(power_event_flags_r & power_event_enable_r);

  always_comb
  begin
    sfr_rdata = 8'h00;
    if (sfr_rd)
    begin
      if (sfr_addr == ADDR_POWER_CONTROL)
      begin
        sfr_rdata = power_control_r;
      end
      else if (sfr_addr == ADDR_SWITCHOVER_CONFIG)
      begin
        sfr_rdata = {6'h00, switchover_config_r};
      end
      else if (sfr_addr == ADDR_POWER_EVENT_ENABLE)
      begin
        sfr_rdata = power_event_enable_r;
      end
      else if (sfr_addr == ADDR_POWER_EVENT_FLAGS)
      begin
        sfr_rdata = power_event_flags_r;
      end
      else if (sfr_addr == ADDR_INT_ENABLE_PRIORITY2)
      begin
        sfr_rdata = {6'h00, master_en_r, 1'b0};
      end
      else if (sfr_addr == ADDR_PERIPHERAL_CONFIG)
      begin
        sfr_rdata = {1'b0, ~on_batt, 6'h00};
      end
    end
  end
endmodule : power_switchover_control

/* File: sim/power_switchover_control_sva.sv */
`timescale 1ns/1ps
module power_switchover_control_sva
  import power_switchover_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic main_supply_ok,
  input wire logic internal_rail_on_battery,
  input wire logic metering_converters_avail,
  input wire logic core_halt,
  input wire logic sleep_mode,
  input wire logic [2:0] clock_divide,
  input wire logic [12:0] core_clock_khz,
  input wire logic power_int_req
);
  // ----------------------------------------
  // shadow of key, disable and master bits
  // ----------------------------------------
  logic key_r, key_nxt, dis_r, dis_nxt, mst_r, mst_nxt;
  // any write closes the key unless it is the key itself
  always_comb
  begin
    key_nxt = key_r;
    dis_nxt = dis_r;
    mst_nxt = mst_r;
    if (sfr_wr)
    begin
      key_nxt = sfr_addr == ADDR_UNLOCK_KEY && sfr_wdata == UNLOCK_VALUE;
      if (sfr_addr == ADDR_SWITCHOVER_CONFIG)
      begin
        dis_nxt = sfr_wdata[SC_DISABLE];
      end
      if (sfr_addr == ADDR_INT_ENABLE_PRIORITY2)
      begin
        mst_nxt = sfr_wdata[IE2_MASTER];
      end
    end
  end
  // shadow registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      key_r <= 1'b0;
      dis_r <= 1'b0;
      mst_r <= 1'b0;
    end
    else
    begin
      key_r <= key_nxt;
      dis_r <= dis_nxt;
      mst_r <= mst_nxt;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // two sync flops plus the state register
  sequence main_lost;
    (!dis_r && !main_supply_ok)[*3];
  endsequence
  sequence pc_write;
    sfr_wr && sfr_addr == ADDR_POWER_CONTROL;
  endsequence
  keyed_write_a: assert property ((key_r ##0 pc_write) |=>
    clock_divide == $past(sfr_wdata[2:0])) else $error("keyed write lost");
  unkeyed_write_a: assert property ((!key_r ##0 pc_write) |=>
    $stable(clock_divide)) else $error("unkeyed write taken");
  clock_rate_a: assert property (core_clock_khz ==
    (13'h1000 >> clock_divide)) else $error("core clock wrong");
  source_bit_a: assert property (sfr_rd &&
    sfr_addr == ADDR_PERIPHERAL_CONFIG |->
    sfr_rdata[PERIPHERAL_SOURCE] != internal_rail_on_battery)
    else $error("source bit wrong");
  main_drop_a: assert property (main_lost |=>
    internal_rail_on_battery) else $error("no switchover");
  adc_off_a: assert property (internal_rail_on_battery |->
    !metering_converters_avail) else $error("converters on battery");
  core_halt_a: assert property (core_halt |->
    internal_rail_on_battery && sleep_mode) else $error("bad halt");
  int_master_a: assert property (power_int_req |-> mst_r)
    else $error("interrupt without master");
  disabled_main_a: assert property (dis_r[*3] |->
    !internal_rail_on_battery) else $error("battery while disabled");
endmodule : power_switchover_control_sva
bind power_switchover_control power_switchover_control_sva u_sva (.*);

/* File: sim/tb_power_switchover_control.sv */
`timescale 1ns/1ps
module tb_power_switchover_control;
  import power_switchover_pkg::*;
  logic clk, sys_rst, sfr_wr, sfr_rd, main_supply_ok, supervisory_input_ok;
  logic battery_control_pin, internal_rail_on_battery, metering_powerdown;
  logic metering_converters_avail, core_halt, sleep_mode, power_int_req;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [2:0] ext_int1_config, clock_divide;
  logic [12:0] core_clock_khz;
  logic [31:0] seed = 32'h99a7;
  int error_cnt = 0;
  int n_compared = 0;
  // short restore delay keeps the run brief
  power_switchover_control #(.RESTORE_DELAY(16)) u_dut (.*);
  // ----------------------------------------
  // clock, helpers and bus tasks
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  // reserved bits forced, bit 3 always reads zero
  function logic [7:0] pc_exp(input logic [7:0] d);
    return (d & POWER_CONTROL_MASK) | 8'h80;
  endfunction : pc_exp
  task chk(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge clk);
    d = sfr_rdata;
    @(negedge clk);
    sfr_rd = 1'b0;
  endtask : rd
  // bounded wait for the rail to reach a source
  task wait_rail(input logic v);
    for (int i = 0; i < 40 && internal_rail_on_battery !== v; i++)
      @(negedge clk);
    chk(internal_rail_on_battery, v);
  endtask : wait_rail
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] d, r;
    {sys_rst, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {3'h4, 16'h0};
    ext_int1_config = 3'h0;
    {main_supply_ok, supervisory_input_ok, battery_control_pin} = 3'h7;
    repeat (6) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    rd(ADDR_POWER_CONTROL, r);
    chk(r, POWER_CONTROL_RST);
    chk(core_clock_khz, 13'h400);
    rd(ADDR_PERIPHERAL_CONFIG, r);
    chk(r[6], 1'b1);
    chk(power_int_req, 1'b0);
    $display("reset test done");
    // every divide code, random upper bits, then an unkeyed retry
    for (int c = 0; c < 8; c++)
    begin
      d = rnd() & 8'hdf;
      d[2:0] = c[2:0];
      wr(ADDR_UNLOCK_KEY, UNLOCK_VALUE);
      wr(ADDR_POWER_CONTROL, d);
      rd(ADDR_POWER_CONTROL, r);
      chk(r, pc_exp(d));
      chk(core_clock_khz, 13'h1000 >> c);
      chk(clock_divide, c[2:0]);
      chk(metering_powerdown, d[6]);
      wr(ADDR_POWER_CONTROL, ~d & 8'hdf);
      rd(ADDR_POWER_CONTROL, r);
      chk(r, pc_exp(d));
    end
    wr(ADDR_UNLOCK_KEY, UNLOCK_VALUE);
    wr(ADDR_POWER_CONTROL, 8'h12);
    chk(core_halt, 1'b0);
    $display("power control test done");
    wr(ADDR_POWER_EVENT_ENABLE, 8'h82);
    main_supply_ok = 1'b0;
    wait_rail(1'b1);
    chk({core_halt, sleep_mode}, 2'h3);
    chk(metering_converters_avail, 1'b0);
    chk(metering_powerdown, 1'b1);
    rd(ADDR_POWER_EVENT_FLAGS, r);
    chk(r, 8'h02);
    rd(ADDR_PERIPHERAL_CONFIG, r);
    chk(r[6], 1'b0);
    chk(power_int_req, 1'b0);
    wr(ADDR_INT_ENABLE_PRIORITY2, 8'h02);
    chk(power_int_req, 1'b1);
    wr(ADDR_POWER_EVENT_ENABLE, 8'h80);
    chk(power_int_req, 1'b0);
    wr(ADDR_POWER_EVENT_FLAGS, 8'h00);
    rd(ADDR_POWER_EVENT_FLAGS, r);
    chk(r, 8'h00);
    main_supply_ok = 1'b1;
    repeat (8) @(negedge clk);
    chk(internal_rail_on_battery, 1'b1);
    wait_rail(1'b0);
    rd(ADDR_POWER_EVENT_FLAGS, r);
    chk(r, 8'h80);
    chk(power_int_req, 1'b1);
    wr(ADDR_POWER_EVENT_FLAGS, 8'h00);
    $display("main supply test done");
    supervisory_input_ok = 1'b0;
    repeat (6) @(negedge clk);
    chk(internal_rail_on_battery, 1'b0);
    wr(ADDR_SWITCHOVER_CONFIG, 8'h01);
    wait_rail(1'b1);
    supervisory_input_ok = 1'b1;
    wait_rail(1'b0);
    wr(ADDR_SWITCHOVER_CONFIG, 8'h00);
    ext_int1_config = EXT_INT1_PIN_EN;
    battery_control_pin = 1'b0;
    wait_rail(1'b1);
    battery_control_pin = 1'b1;
    wait_rail(1'b0);
    wr(ADDR_SWITCHOVER_CONFIG, 8'h02);
    main_supply_ok = 1'b0;
    battery_control_pin = 1'b0;
    repeat (6) @(negedge clk);
    chk(internal_rail_on_battery, 1'b0);
    {main_supply_ok, battery_control_pin} = 2'h3;
    rd(ADDR_POWER_EVENT_FLAGS, r);
    chk(r, 8'h82);
    chk(power_int_req, 1'b1);
    $display("switchover test done");
    // second reset in mid-run must drop the interrupt again
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk(power_int_req, 1'b0);
    rd(ADDR_POWER_CONTROL, r);
    chk(r, POWER_CONTROL_RST);
    $display("mid-run reset test done");
    end_of_test();
  end
  // the tests need under a thousand cycles; allow five times that
  initial
  begin
    #20000;
    error_cnt++;
    end_of_test();
  end
endmodule : tb_power_switchover_control
